// ### dtc_dma_model.sv
// Behavioural DMA controller that acknowledges timer requests
`timescale 1ns/100ps
`default_nettype none

module dtc_dma_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       dma_req_i,
  output logic            dma_ack_o
);
  logic [3:0] wait_cnt;
  logic       busy;

  // Serve one request after the chosen delay; busy stops a second ack
  // before the request has dropped, as a real controller would
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_ack_o <= 1'b0;
      wait_cnt  <= 4'h0;
      busy      <= 1'b0;
    end else if (busy) begin
      dma_ack_o <= 1'b0;
      busy      <= dma_req_i;
    end else if (en_i && dma_req_i) begin
      if (wait_cnt == delay_i) begin
        dma_ack_o <= 1'b1;  // One-cycle pulse
        busy      <= 1'b1;
        wait_cnt  <= 4'h0;
      end else begin
        dma_ack_o <= 1'b0;
        wait_cnt  <= wait_cnt + 4'h1;
      end
    end else begin
      dma_ack_o <= 1'b0;
    end
  end
endmodule : dtc_dma_model
`default_nettype wire

// ### dtc_map.svh
// Register offsets, field positions, reset values and step constants of the timer channel
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Word offsets on the register bus
`define DTC_OFF_CTRL      4'h0
`define DTC_OFF_MATCH     4'h4
`define DTC_OFF_LATCH     4'h8
`define DTC_OFF_COUNT     4'hc

// Control word lanes: mode [31:16], extended mode [15:8], event flags [7:0]
`define DTC_MODE_LSB      16
`define DTC_EXT_LSB       8

// Mode control fields
`define DTC_PS_MSB        15
`define DTC_PS_LSB        8
`define DTC_CE_MSB        7
`define DTC_CE_LSB        6
`define DTC_OM_BIT        5
`define DTC_MATCH_REQUEST_ENABLE_BIT      4
`define DTC_FRR_BIT       3
`define DTC_CLK_MSB       2
`define DTC_CLK_LSB       1
`define DTC_RST_BIT       0

// Extended mode fields, reserved bits held at zero
`define DTC_DMA_BIT       7
`define DTC_WIDE_BIT      0
`define DTC_EXT_MASK      8'h81

// Event flag fields
`define DTC_REF_BIT       1
`define DTC_CAP_BIT       0

// Reset values
`define DTC_MODE_RST      16'h0000
`define DTC_EXT_RST       8'h00
`define DTC_WORD_RST      32'h0000_0000
`define DTC_PRE_RST       8'h00
`define DTC_DIV_RST       4'h0
`define DTC_PIN_IDLE      1'b1

// Counter steps and system clock divider
`define DTC_STEP_NARROW   32'h0000_0001
`define DTC_STEP_WIDE     32'h0001_0001
`define DTC_DIV16_LAST    4'hf

`endif

// ### dtc_pin_sync.sv
// Three-stage synchroniser and edge detector for the timer input pin
`timescale 1ns/100ps
`default_nettype none

module dtc_pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic s1;
  logic s2;
  logic s3;
  logic settled;

  // A change counts only once the second and third stages agree
  assign settled = (s2 == s3) && (s3 != level_o);
  assign rise_o  = settled && s3;
  assign fall_o  = settled && !s3;

  // Pin chain; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (settled) begin
        level_o <= s3;
      end
    end
  end

endmodule : dtc_pin_sync

`default_nettype wire

// ### dtc_pkg.sv
// Field encodings of the timer channel
`default_nettype none

package dtc_pkg;

  // Count source select
  typedef enum logic [1:0] {
    DTC_SRC_STOP  = 2'h0,
    DTC_SRC_SYS   = 2'h1,
    DTC_SRC_DIV16 = 2'h2,
    DTC_SRC_PIN   = 2'h3
  } dtc_clk_src_t;

  // Capture edge select
  typedef enum logic [1:0] {
    DTC_CAP_OFF  = 2'h0,
    DTC_CAP_RISE = 2'h1,
    DTC_CAP_FALL = 2'h2,
    DTC_CAP_ANY  = 2'h3
  } dtc_cap_edge_t;

endpackage : dtc_pkg

`default_nettype wire

// ### dtc_timer.sv
// One 32-bit timer channel with prescaler, capture, compare, output pin and request routing
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.svh"

module dtc_timer #(
  parameter int ADR_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             timer_input_pin_i,
  output logic                  timer_output_pin_o,
  output logic                  interrupt_request_line_o,
  output logic                  dma_req_o,
  input  wire logic             dma_ack_i
);

  // Byte lane merge for partial writes
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  // Compare, limited to the upper half in wide step mode
  function automatic logic match_eq(input logic [31:0] a,
                                    input logic [31:0] b,
                                    input logic        wide);
    return wide ? (a[31:16] == b[31:16]) : (a == b);
  endfunction : match_eq

  logic [15:0] mode_control_reg;
  logic [7:0]  extended_mode_reg;
  logic        match_flag;
  logic        latch_event_flag;
  logic [31:0] match_value_reg;
  logic [31:0] latched_count_reg;
  logic [31:0] running_count_reg;
  logic [7:0]  pre_cnt;
  logic [3:0]  div_cnt;
  logic        restart_pend;
  logic        pin_level;
  logic        pin_rise;
  logic        pin_fall;

  // Mode field decode
  logic [7:0]              prescale_value;
  dtc_pkg::dtc_cap_edge_t  cap_edge;
  dtc_pkg::dtc_clk_src_t   clk_src;
  logic                    output_mode_select;
  logic                    match_request_enable;
  logic                    free_run_restart_select;
  logic                    run;
  logic                    dma_route_select;
  logic                    wide_step_mode;

  assign prescale_value          = mode_control_reg[`DTC_PS_MSB:`DTC_PS_LSB];
  assign cap_edge                = dtc_pkg::dtc_cap_edge_t'(
                                     mode_control_reg[`DTC_CE_MSB:`DTC_CE_LSB]);
  assign clk_src                 = dtc_pkg::dtc_clk_src_t'(
                                     mode_control_reg[`DTC_CLK_MSB:`DTC_CLK_LSB]);
  assign output_mode_select      = mode_control_reg[`DTC_OM_BIT];
  assign match_request_enable    = mode_control_reg[`DTC_MATCH_REQUEST_ENABLE_BIT];
  assign free_run_restart_select = mode_control_reg[`DTC_FRR_BIT];
  assign run                     = mode_control_reg[`DTC_RST_BIT];
  assign dma_route_select        = extended_mode_reg[`DTC_DMA_BIT];
  assign wide_step_mode          = extended_mode_reg[`DTC_WIDE_BIT];

  // Pin synchroniser; adds two to three cycles of delay
  dtc_pin_sync i_dtc_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (timer_input_pin_i),
    .level_o (pin_level),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // Bus decode; a write commits at the edge where the master sees ack
  logic        bus_req;
  logic        bus_wr;
  logic        in_map;
  logic [3:0]  bus_off;
  logic        wr_ctrl;
  logic        wr_match;
  logic        wr_count;
  logic [31:0] word0;
  logic [31:0] next_word0;
  logic        sw_reset_edge;

  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign bus_wr   = bus_req && wb_we_i && wb_ack_o;
  assign in_map   = (wb_adr_i[ADR_W-1:4] == '0);
  assign bus_off  = {wb_adr_i[3:2], 2'h0};
  assign wr_ctrl  = bus_wr && in_map && (bus_off == `DTC_OFF_CTRL);
  assign wr_match = bus_wr && in_map && (bus_off == `DTC_OFF_MATCH);
  assign wr_count = bus_wr && in_map && (bus_off == `DTC_OFF_COUNT);
  assign word0    = {mode_control_reg, extended_mode_reg & `DTC_EXT_MASK,
                     6'h00, match_flag, latch_event_flag};
  assign next_word0 = byte_merge(word0, wb_dat_i, wb_sel_i);
  // Falling reset bit written while the timer ran
  assign sw_reset_edge = wr_ctrl && run
                         && !next_word0[`DTC_MODE_LSB + `DTC_RST_BIT];

  // Count source select, gated by the enable
  logic src_tick;
  logic count_tick;
  logic [31:0] cnt_inc;
  logic match_hit;
  logic cap_hit;

  always_comb begin
    unique case (clk_src)
      dtc_pkg::DTC_SRC_STOP:  src_tick = 1'b0;
      dtc_pkg::DTC_SRC_SYS:   src_tick = 1'b1;
      dtc_pkg::DTC_SRC_DIV16: src_tick = (div_cnt == `DTC_DIV16_LAST);
      dtc_pkg::DTC_SRC_PIN:   src_tick = pin_fall;
    endcase
    src_tick = src_tick && run;
  end

  assign count_tick = src_tick && (pre_cnt == prescale_value);
  assign cnt_inc    = running_count_reg
                      + (wide_step_mode ? `DTC_STEP_WIDE : `DTC_STEP_NARROW);
  // Flag on the count that makes the counter equal the reference
  assign match_hit  = count_tick && !restart_pend
                      && match_eq(cnt_inc, match_value_reg, wide_step_mode);
  // Pin as count source while capturing is undefined, so no guard here
  assign cap_hit    = run && ((pin_rise && cap_edge[0])
                              || (pin_fall && cap_edge[1]));

  // System clock divider runs free, unrelated to the timer phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= `DTC_DIV_RST;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i || !run || sw_reset_edge) begin
      pre_cnt <= `DTC_PRE_RST;
    end else if (src_tick) begin
      pre_cnt <= count_tick ? `DTC_PRE_RST : pre_cnt + 8'h01;
    end
  end

  // Running counter; reads leave it alone, any write clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || !run || sw_reset_edge || wr_count || restart_pend) begin
      running_count_reg <= `DTC_WORD_RST;
    end else if (count_tick) begin
      running_count_reg <= cnt_inc;
    end
  end

  // Restart clears the counter in the cycle after it reached the reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_pend <= 1'b0;
    end else begin
      restart_pend <= match_hit && free_run_restart_select;
    end
  end

  // Mode, extended mode and reference stay writable under software reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_control_reg  <= `DTC_MODE_RST;
      extended_mode_reg <= `DTC_EXT_RST;
      match_value_reg   <= `DTC_WORD_RST;
    end else if (sw_reset_edge) begin
      mode_control_reg  <= next_word0[31:16];
      extended_mode_reg <= `DTC_EXT_RST;
      match_value_reg   <= `DTC_WORD_RST;
    end else begin
      if (wr_ctrl) begin
        mode_control_reg  <= next_word0[31:16];
        extended_mode_reg <= next_word0[15:8] & `DTC_EXT_MASK;
      end
      if (wr_match) begin
        match_value_reg <= byte_merge(match_value_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Capture latch
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_edge) begin
      latched_count_reg <= `DTC_WORD_RST;
    end else if (cap_hit) begin
      latched_count_reg <= running_count_reg;
    end
  end

  // Event flags: write-one or DMA acknowledge clears, a new event wins
  logic clr_match;
  logic clr_cap;
  logic dma_clear;

  assign dma_clear = dma_ack_i && dma_route_select;
  assign clr_match = dma_clear || (wr_ctrl && wb_sel_i[0]
                                   && wb_dat_i[`DTC_REF_BIT]);
  assign clr_cap   = dma_clear || (wr_ctrl && wb_sel_i[0]
                                   && wb_dat_i[`DTC_CAP_BIT]);

  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_edge) begin
      match_flag       <= 1'b0;
      latch_event_flag <= 1'b0;
    end else begin
      match_flag       <= (match_flag && !clr_match) || match_hit;
      latch_event_flag <= (latch_event_flag && !clr_cap) || cap_hit;
    end
  end

  // Output pin; toggle mode keeps its level, pulse mode idles high
  always_ff @(posedge clk_i) begin
    if (rst_i || sw_reset_edge) begin
      timer_output_pin_o <= `DTC_PIN_IDLE;
    end else if (match_hit) begin
      timer_output_pin_o <= output_mode_select ? !timer_output_pin_o
                                               : 1'b0;
    end else if (!output_mode_select) begin
      timer_output_pin_o <= `DTC_PIN_IDLE;
    end
  end

  // Request routing; lines stay up while an enabled flag stays set
  logic match_req;
  logic cap_req;
  logic any_req;

  assign match_req = match_flag && match_request_enable;
  assign cap_req   = latch_event_flag && (cap_edge != dtc_pkg::DTC_CAP_OFF);
  assign any_req   = match_req || cap_req;
  assign dma_req_o = any_req && dma_route_select;
  assign interrupt_request_line_o = any_req && !dma_route_select;

  // Bus answer: one wait state, data registered with ack
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (in_map) begin
      unique case (bus_off)
        `DTC_OFF_CTRL:  rd_mux = word0;
        `DTC_OFF_MATCH: rd_mux = match_value_reg;
        `DTC_OFF_LATCH: rd_mux = latched_count_reg;
        `DTC_OFF_COUNT: rd_mux = running_count_reg;
        default:        rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DTC_WORD_RST;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_prescale_wrap: assert property (count_tick && run && !sw_reset_edge
                                    |=> pre_cnt == 8'h00)
    else $error("prescaler did not wrap after count tick");
  a_capture_copy: assert property (cap_hit && !sw_reset_edge
                                   |=> latched_count_reg == $past(running_count_reg)
                                       && latch_event_flag)
    else $error("capture did not latch counter");
  a_pulse_low: assert property (match_hit && !output_mode_select && !sw_reset_edge
                                |=> !timer_output_pin_o)
    else $error("pulse mode pin not low after match");
  a_toggle_pin: assert property (match_hit && output_mode_select && !sw_reset_edge
                                 |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("toggle mode pin did not toggle");
  a_restart_zero: assert property (match_hit && free_run_restart_select
                                   |-> ##2 running_count_reg == 32'h0000_0000)
    else $error("restart did not clear counter");
  a_hold_reset: assert property (!run |=> running_count_reg == 32'h0000_0000)
    else $error("counter moved while held in reset");
  a_flag_set_wins: assert property (match_hit && !sw_reset_edge |=> match_flag)
    else $error("match flag lost");
  a_w1c_clear: assert property (wr_ctrl && wb_sel_i[0]
                                && wb_dat_i[`DTC_CAP_BIT] && !cap_hit
                                |=> !latch_event_flag)
    else $error("capture flag not cleared by write one");
  a_route_irq: assert property (interrupt_request_line_o
                                |-> !dma_route_select && (match_flag || latch_event_flag))
    else $error("interrupt asserted without routed flag");
  a_count_write: assert property (wr_count |=> running_count_reg == 32'h0000_0000)
    else $error("counter write did not clear");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Only a control write can drop a raised interrupt, so flags must not leak away
  a_irq_holds: assert property (interrupt_request_line_o && !wr_ctrl
                                |=> interrupt_request_line_o)
    else $error("interrupt dropped without a flag clear");
  a_dma_ack_clear: assert property (dma_clear && !match_hit && !cap_hit
                                    |=> !match_flag && !latch_event_flag)
    else $error("dma acknowledge did not clear flags");

  c_match_irq: cover property (match_hit ##1 interrupt_request_line_o);
  c_capture:   cover property (cap_hit ##1 latch_event_flag);
  c_dma_ack:   cover property (dma_req_o ##1 dma_ack_i);
  c_toggle:    cover property (match_hit && output_mode_select);

endmodule : dtc_timer

`default_nettype wire

// ### tb_dma_capable_timer_channel.sv
// Self-checking testbench for the timer channel with a DMA controller model
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.svh"

module tb_dma_capable_timer_channel;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0000_0000;
  logic        pin      = 1'b0;
  logic        dma_en   = 1'b0;
  logic [3:0]  dma_dly  = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        out_pin;
  logic        irq;
  logic        dreq;
  logic        dack;
  int          n_errors = 0;
  int          n_tests  = 0;

  // 100 MHz system clock
  always #5 clk_i = ~clk_i;

  dtc_timer #(.ADR_W(8)) i_dtc_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_input_pin_i(pin), .timer_output_pin_o(out_pin),
    .interrupt_request_line_o(irq), .dma_req_o(dreq), .dma_ack_i(dack));

  dtc_dma_model i_dtc_dma_model (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(dma_en), .delay_i(dma_dly),
    .dma_req_i(dreq), .dma_ack_o(dack));

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("bus ack", 32'h1, 32'h0);
      tally_and_finish();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [3:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    xfer(1'b1, {4'h0, o}, d, s, q);
  endtask : wr

  task automatic rd(input logic [3:0] o, output logic [31:0] q);
    xfer(1'b0, {4'h0, o}, 32'h0, 4'hf, q);
  endtask : rd

  // Mode and extended mode only; the flag lane stays untouched
  task automatic setc(input logic [31:0] w);
    wr(`DTC_OFF_CTRL, w, 4'he);
  endtask : setc

  function automatic logic [31:0] cw(input logic [7:0] ps, input logic [1:0] ce,
      input logic [2:0] f, input logic [1:0] src, input logic en, input logic [7:0] x);
    return {ps, ce, f, src, en, x, 8'h00};
  endfunction : cw

  // Bounded wait on the output pin or the DMA request
  task automatic wait_for(input logic use_dma, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((use_dma ? dreq : out_pin) !== v && n < 200);
    if (n >= 200) begin
      chk("wait bound", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : wait_for

  task automatic pin_set(input logic v);
    @(posedge clk_i);
    pin <= v;
    repeat (6) @(posedge clk_i);  // Covers the synchroniser delay
  endtask : pin_set

  // Two reads exactly 64 cycles apart; soft reset first fixes prescaler phase
  task automatic measure(input logic [31:0] w, input logic [31:0] exp, input string what);
    logic [31:0] c0;
    logic [31:0] c1;
    setc(32'h0);
    setc(w);
    rd(`DTC_OFF_COUNT, c0);
    repeat (61) @(posedge clk_i);
    rd(`DTC_OFF_COUNT, c1);
    chk(what, exp, c1 - c0);
  endtask : measure

  task automatic scen_regs;
    logic [31:0] q;
    rd(`DTC_OFF_CTRL, q);
    chk("ctrl reset", 32'h0, q);
    chk("pin idle", 32'h1, out_pin);
    xfer(1'b1, 8'h10, 32'hffff_ffff, 4'hf, q);
    xfer(1'b0, 8'h10, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
    wr(`DTC_OFF_MATCH, 32'h1234_5678, 4'hf);
    rd(`DTC_OFF_MATCH, q);
    chk("match in reset", 32'h1234_5678, q);
    setc(cw(8'h5a, 2'h0, 3'h0, 2'h0, 1'b1, 8'hff));
    rd(`DTC_OFF_CTRL, q);
    chk("ext reserved", 32'h5a01_8100, q);
    setc(cw(8'h5a, 2'h0, 3'h0, 2'h0, 1'b0, 8'h00));
    rd(`DTC_OFF_CTRL, q);
    chk("soft reset ctrl", 32'h5a00_0000, q);
    rd(`DTC_OFF_MATCH, q);
    chk("soft reset match", 32'h0, q);
    wr(`DTC_OFF_LATCH, 32'hffff_ffff, 4'hf);
    rd(`DTC_OFF_LATCH, q);
    chk("latch read-only", 32'h0, q);
    $display("Test registers done");
  endtask : scen_regs

  task automatic scen_count;
    measure(cw(8'h00, 2'h0, 3'h0, 2'h1, 1'b1, 8'h00), 32'd64, "sys div1");
    measure(cw(8'h03, 2'h0, 3'h0, 2'h1, 1'b1, 8'h00), 32'd16, "prescale 4");
    measure(cw(8'hff, 2'h0, 3'h0, 2'h1, 1'b1, 8'h00), 32'd0, "prescale 256");
    measure(cw(8'h00, 2'h0, 3'h0, 2'h2, 1'b1, 8'h00), 32'd4, "sys div16");
    measure(cw(8'h01, 2'h0, 3'h0, 2'h1, 1'b1, 8'h01), 32'h0020_0020, "wide");
    measure(cw(8'h00, 2'h0, 3'h0, 2'h0, 1'b1, 8'h00), 32'd0, "stopped");
    measure(cw(8'h00, 2'h0, 3'h0, 2'h1, 1'b0, 8'h00), 32'd0, "disabled");
    $display("Test counting done");
  endtask : scen_count

  task automatic scen_pin;
    logic [31:0] q;
    setc(32'h0);
    setc(cw(8'h00, 2'h0, 3'h0, 2'h3, 1'b1, 8'h00));  // Capture off
    wr(`DTC_OFF_COUNT, 32'hffff_ffff, 4'hf);
    repeat (5) begin
      pin_set(1'b1);
      pin_set(1'b0);
    end
    rd(`DTC_OFF_COUNT, q);
    chk("pin falls", 32'd5, q);
    $display("Test pin source done");
  endtask : scen_pin

  task automatic scen_match;
    logic [31:0] q;
    setc(32'h0);
    wr(`DTC_OFF_MATCH, 32'd20, 4'hf);
    setc(cw(8'h00, 2'h0, 3'h3, 2'h1, 1'b1, 8'h00));
    wait_for(1'b0, 1'b0);
    @(posedge clk_i);
    chk("pulse width", 32'h1, out_pin);
    chk("match irq", 32'h1, irq);
    chk("match no dma", 32'h0, dreq);
    repeat (30) @(posedge clk_i);
    rd(`DTC_OFF_COUNT, q);
    chk("restart", 32'h1, q <= 32'd20);
    setc(cw(8'h00, 2'h0, 3'h3, 2'h0, 1'b1, 8'h00));
    rd(`DTC_OFF_CTRL, q);
    chk("match flag", 32'h2, q & 32'hff);
    wr(`DTC_OFF_CTRL, 32'h0, 4'h1);
    @(posedge clk_i);
    chk("zero write keeps", 32'h1, irq);
    wr(`DTC_OFF_CTRL, 32'h2, 4'h1);
    @(posedge clk_i);
    chk("one write clears", 32'h0, irq);
    setc(32'h0);
    wr(`DTC_OFF_MATCH, 32'd20, 4'hf);
    setc(cw(8'h00, 2'h0, 3'h4, 2'h1, 1'b1, 8'h00));
    wait_for(1'b0, 1'b0);
    @(posedge clk_i);
    chk("toggle holds", 32'h0, out_pin);
    chk("irq disabled", 32'h0, irq);
    rd(`DTC_OFF_COUNT, q);
    chk("free run", 32'h1, q > 32'd20);
    rd(`DTC_OFF_CTRL, q);
    chk("flag unenabled", 32'h2, q & 32'hff);
    // Cleared at the write, then one more count before the read samples it
    wr(`DTC_OFF_COUNT, 32'hffff_ffff, 4'h1);
    rd(`DTC_OFF_COUNT, q);
    chk("count write clears", 32'h1, q);
    $display("Test compare done");
  endtask : scen_match

  task automatic scen_capture;
    logic [31:0] q;
    for (int ce = 0; ce < 4; ce++) begin
      setc(32'h0);
      setc(cw(8'h00, ce[1:0], 3'h0, 2'h1, 1'b1, 8'h00));
      pin_set(1'b1);
      chk("irq on rise", ce[0], irq);
      rd(`DTC_OFF_LATCH, q);
      chk("latch on rise", ce[0], q != 32'h0);
      rd(`DTC_OFF_CTRL, q);
      chk("flag on rise", ce[0], q[0]);
      wr(`DTC_OFF_CTRL, 32'h1, 4'h1);
      pin_set(1'b0);
      rd(`DTC_OFF_CTRL, q);
      chk("flag on fall", ce[1], q[0]);
    end
    $display("Test capture done");
  endtask : scen_capture

  // Controller first stalls, then acks promptly or slowly
  task automatic scen_dma;
    logic [31:0] q;
    for (int i = 0; i < 2; i++) begin
      dma_en  <= 1'b0;
      dma_dly <= (i == 0) ? 4'h0 : 4'h6;
      setc(32'h0);
      setc(cw(8'h00, 2'h3, 3'h0, 2'h1, 1'b1, 8'h80));
      pin_set(~pin);
      chk("dma raised", 32'h1, dreq);
      chk("irq quiet", 32'h0, irq);
      repeat (20) @(posedge clk_i);
      chk("dma held", 32'h1, dreq);
      dma_en <= 1'b1;
      wait_for(1'b1, 1'b0);
      rd(`DTC_OFF_CTRL, q);
      chk("ack clears", 32'h0, q & 32'hff);
    end
    $display("Test dma done");
  endtask : scen_dma

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    scen_regs();
    scen_count();
    scen_pin();
    scen_match();
    scen_capture();
    scen_dma();
    tally_and_finish();
  end
endmodule : tb_dma_capable_timer_channel
`default_nettype wire
